/* dmx_pkg.sv */
// Purpose: Shared constants and types for the peripheral transfer control.
// Assumes: Mode lines packed as {mode_bit0, mode_bit1, mode_bit2, mode_bit3}.
// Notes:   Queue control block layout and action codes are fixed here.
package dmx_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_SLOTS = 10;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int MODE_W = 4;
   localparam int CHAN_PAIRS = 16;
   localparam int CHAN_SEL_W = 4;

   // ----------------------------------------------------------------
   // Microcode action codes, sampled at the stage-8 edge
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ACT_NOP = 4'h0,
      ACT_SET_EN = 4'h1,
      ACT_RESET_EN = 4'h2,
      ACT_LATCH_MODE = 4'h3,
      ACT_SET_CLR_PRI = 4'h4,
      ACT_SET_STROBE = 4'h5,
      ACT_RESET_STROBE = 4'h6,
      ACT_EN_DATA_IN = 4'h7,
      ACT_EN_DATA_OUT = 4'h8,
      ACT_TRIGGER = 4'h9,
      ACT_CALC_ADDR = 4'ha,
      ACT_DATA_OFF = 4'hb
   } microcode_action_e;

   // ----------------------------------------------------------------
   // Transfer type codes
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_QUEUE = 4'h0;
   localparam logic [3:0] MODE_SINGLE = 4'h4;
   localparam logic [3:0] MODE_BURST16 = 4'h5;
   localparam logic [3:0] MODE_BURST32 = 4'h7;
   localparam logic [3:0] MODE_TABLE = 4'h8;
   localparam logic [3:0] MODE_BURST_TABLE = 4'h9;
   localparam logic [3:0] MODE_CHAIN = 4'hc;

   // ----------------------------------------------------------------
   // Memory word offsets for chain and queue control blocks
   // ----------------------------------------------------------------
   localparam logic [17:0] CHAIN_NEXT_OFS = 18'h00001;
   localparam logic [17:0] QCB_TOP_OFS = 18'h00000;
   localparam logic [17:0] QCB_BOTTOM_OFS = 18'h00001;
   localparam logic [17:0] QCB_MASK_OFS = 18'h00002;
   localparam logic [17:0] QCB_BUF_OFS = 18'h00003;
   localparam logic [1:0] CHAIN_READS = 2'h1;
   localparam logic [1:0] QUEUE_READS = 2'h2;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   localparam logic [17:0] ADDR_RESET = 18'h00000;

   typedef enum logic [1:0] {
      CALC_IDLE = 2'b00,
      CALC_READ = 2'b01,
      CALC_WRITE = 2'b11,
      CALC_DONE = 2'b10
   } calc_state_e;

   function automatic logic mode_legal(input logic [3:0] m);
      return (m == MODE_QUEUE) || (m == MODE_SINGLE) ||
         (m == MODE_BURST16) || (m == MODE_BURST32) ||
         (m == MODE_TABLE) || (m == MODE_BURST_TABLE) ||
         (m == MODE_CHAIN);
   endfunction
endpackage

/* dmx_slot_arbiter.sv */
// Purpose: Picks the highest-numbered requesting slot and holds its grant.
// Assumes: Requests are already synchronised and active high.
// Notes:   A grant, once given, stays until the clear-priority net is set.
`timescale 1ns/100ps
module dmx_slot_arbiter #(
   parameter int SLOTS = 10
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic clear,
   input wire logic [SLOTS-1:0] req,
   output logic [SLOTS-1:0] grant_q
);
   logic [SLOTS-1:0] pick_d;

   // ----------------------------------------------------------------
   // Priority pick
   // ----------------------------------------------------------------
   // highest slot wins
   always_comb begin
      pick_d = '0;
      for (int i = 0; i < SLOTS; i++) begin
         if (req[i]) begin
            pick_d = '0;
            pick_d[i] = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Grant register
   // ----------------------------------------------------------------
   // sample only while enabled
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         grant_q <= '0;
      end else if (enable && grant_q == '0) begin
         grant_q <= pick_d;
      end
   end
endmodule

/* dmx_transfer_control.sv */
// Purpose: Address and data phase control for direct peripheral transfers.
// Assumes: Actions are valid only in the cycle STAGE8 is high.
// Notes:   Burst and wide modes run as their single-word equivalents.
//
// Overview of operation
// - Set-enable action sets enable flag at stage 8; broadcast to controllers.
// - Grant goes to highest-numbered requesting slot, all others inactive.
// - Latch-mode action captures mode lines for the microcode branch.
// - Clear-priority action sets clear net at stage 8 and drops grants.
// - Reset-enable action clears both enable broadcast and clear net.
// - Four mode bits decode to the seven legal types, rest illegal.
// - Fifth mode line: one is input toward memory, zero output.
// - Illegal latched mode raises machine check, no address calculation runs.
// - Set-strobe registers internally, then one timer tick later drives out.
// - Address phase actions work while a data phase is in progress.
// - Single-word: address from channel pair, bump both, end when range zero.
// - Chain: memory word is address, write back plus one, compare next.
// - Table: address bus is the memory address, never end of range.
// - Queue input: add word at bottom, end when queue becomes full.
// - Input: capture bus data on trigger, write it to the write buffer.
// - Output: read memory, capture returning data, drive data bus.
// - Queue output: take from top; empty queue ends range, sends zero.
`timescale 1ns/100ps
module dmx_transfer_control (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic STAGE8,
   input wire logic [3:0] MICROCODE_ACTION,
   input wire logic MEM_TIMER_TICK,
   input wire logic [dmx_pkg::NUM_SLOTS-1:0] XFER_REQUEST_N,
   input wire logic MODE_BIT0,
   input wire logic MODE_BIT1,
   input wire logic MODE_BIT2,
   input wire logic MODE_BIT3,
   input wire logic INPUT_DIRECTION,
   input wire logic [dmx_pkg::ADDR_W-1:0] PERIPH_ADDR_BUS,
   input wire logic [dmx_pkg::DATA_W-1:0] PERIPH_DATA_IN,
   output logic [dmx_pkg::DATA_W-1:0] PERIPH_DATA_OUT,
   output logic PERIPH_DATA_OE,
   output logic XFER_ENABLE_BROADCAST,
   output logic CLEAR_PRIORITY_NET,
   output logic [dmx_pkg::NUM_SLOTS-1:0] XFER_GRANT,
   output logic DATA_STROBE,
   output logic END_OF_RANGE,
   output logic MACHINE_CHECK,
   output logic [dmx_pkg::MODE_W-1:0] MODE_LATCHED,
   output logic INPUT_LATCHED,
   output logic CALC_BUSY,
   input wire logic CHAN_WR,
   input wire logic CHAN_WR_RANGE,
   input wire logic [dmx_pkg::CHAN_SEL_W-1:0] CHAN_SEL,
   input wire logic [dmx_pkg::ADDR_W-1:0] CHAN_WDATA,
   output logic MEM_REQ,
   output logic MEM_WE,
   output logic [dmx_pkg::ADDR_W-1:0] MEM_ADDR,
   output logic [dmx_pkg::ADDR_W-1:0] MEM_WDATA,
   input wire logic MEM_ACK,
   input wire logic [dmx_pkg::ADDR_W-1:0] MEM_RDATA,
   output logic [dmx_pkg::ADDR_W-1:0] MEM_ADDR_REG,
   output logic WB_WRITE,
   output logic [dmx_pkg::DATA_W-1:0] WB_WDATA,
   output logic MEM_READ,
   input wire logic RETURN_VALID,
   input wire logic [dmx_pkg::DATA_W-1:0] RETURN_DATA
);
   import dmx_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [NUM_SLOTS-1:0] req_n_s1_q, req_n_s2_q;
   logic [4:0] mode_s1_q, mode_s2_q;
   logic [ADDR_W-1:0] abus_s1_q, abus_s2_q;
   logic [DATA_W-1:0] dbus_s1_q, dbus_s2_q;

   always_ff @(posedge MCLK) begin
      if (RST) begin
         req_n_s1_q <= '1;
         req_n_s2_q <= '1;
         mode_s1_q <= '0;
         mode_s2_q <= '0;
         abus_s1_q <= '0;
         abus_s2_q <= '0;
         dbus_s1_q <= '0;
         dbus_s2_q <= '0;
      end else begin
         req_n_s1_q <= XFER_REQUEST_N;
         req_n_s2_q <= req_n_s1_q;
         mode_s1_q <= {MODE_BIT0, MODE_BIT1, MODE_BIT2, MODE_BIT3,
            INPUT_DIRECTION};
         mode_s2_q <= mode_s1_q;
         abus_s1_q <= PERIPH_ADDR_BUS;
         abus_s2_q <= abus_s1_q;
         dbus_s1_q <= PERIPH_DATA_IN;
         dbus_s2_q <= dbus_s1_q;
      end
   end

   microcode_action_e act;
   logic act_valid;
   assign act = microcode_action_e'(MICROCODE_ACTION);
   assign act_valid = STAGE8;

   // ----------------------------------------------------------------
   // Address phase
   // ----------------------------------------------------------------
   // enable flag set at stage 8
   // reset action drops enable and clear net
   // runs independently of the data phase
   always_ff @(posedge MCLK) begin
      if (RST) begin
         XFER_ENABLE_BROADCAST <= 1'b0;
         CLEAR_PRIORITY_NET <= 1'b0;
      end else if (act_valid) begin
         if (act == ACT_SET_EN) begin
            XFER_ENABLE_BROADCAST <= 1'b1;
         end
         if (act == ACT_RESET_EN) begin
            XFER_ENABLE_BROADCAST <= 1'b0;
            CLEAR_PRIORITY_NET <= 1'b0;
         end
         // clear net ends the address phase
         if (act == ACT_SET_CLR_PRI) begin
            CLEAR_PRIORITY_NET <= 1'b1;
         end
      end
   end

   // Controllers that lost must see the clear net and request again.
   // grants drop with the clear action
   dmx_slot_arbiter #(
      .SLOTS(NUM_SLOTS)
   ) u_arb (
      .clk(MCLK),
      .rst(RST),
      .enable(XFER_ENABLE_BROADCAST),
      .clear(act_valid && act == ACT_SET_CLR_PRI),
      .req(~req_n_s2_q),
      .grant_q(XFER_GRANT)
   );

   // mode lines latched for the jump net
   // direction held alongside the type code
   always_ff @(posedge MCLK) begin
      if (RST) begin
         MODE_LATCHED <= MODE_QUEUE;
         INPUT_LATCHED <= 1'b0;
      end else if (act_valid && act == ACT_LATCH_MODE) begin
         MODE_LATCHED <= mode_s2_q[4:1];
         INPUT_LATCHED <= mode_s2_q[0];
      end
   end

   // ----------------------------------------------------------------
   // Strobe
   // ----------------------------------------------------------------
   logic internal_strobe_q;

   // internal stage then timer tick to the pin
   always_ff @(posedge MCLK) begin
      if (RST) begin
         internal_strobe_q <= 1'b0;
         DATA_STROBE <= 1'b0;
      end else if (act_valid && act == ACT_RESET_STROBE) begin
         internal_strobe_q <= 1'b0;
         DATA_STROBE <= 1'b0;
      end else begin
         if (act_valid && act == ACT_SET_STROBE) begin
            internal_strobe_q <= 1'b1;
         end
         if (MEM_TIMER_TICK) begin
            DATA_STROBE <= internal_strobe_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Channel pairs
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0] chan_addr_q [CHAN_PAIRS];
   logic [ADDR_W-1:0] chan_range_q [CHAN_PAIRS];
   logic [CHAN_SEL_W-1:0] sel;
   logic [ADDR_W-1:0] range_inc;
   logic start_calc;
   logic [3:0] calc_mode;

   assign sel = abus_s2_q[CHAN_SEL_W-1:0];
   assign range_inc = chan_range_q[sel] + 1'b1;
   assign start_calc = act_valid && act == ACT_CALC_ADDR;
   // Burst requests fall back to their single-word form.
   assign calc_mode = (MODE_LATCHED == MODE_BURST16 ||
      MODE_LATCHED == MODE_BURST32) ? MODE_SINGLE :
      (MODE_LATCHED == MODE_BURST_TABLE) ? MODE_TABLE : MODE_LATCHED;

   // bump address and range of the pair
   always_ff @(posedge MCLK) begin
      if (CHAN_WR) begin
         if (CHAN_WR_RANGE) begin
            chan_range_q[CHAN_SEL] <= CHAN_WDATA;
         end else begin
            chan_addr_q[CHAN_SEL] <= CHAN_WDATA;
         end
      end else if (start_calc && calc_mode == MODE_SINGLE &&
            !CALC_BUSY) begin
         chan_addr_q[sel] <= chan_addr_q[sel] + 1'b1;
         chan_range_q[sel] <= range_inc;
      end
   end

   // ----------------------------------------------------------------
   // Address calculation sequencer
   // ----------------------------------------------------------------
   calc_state_e state_q;
   logic [1:0] rd_idx_q, rd_last_q;
   logic [ADDR_W-1:0] base_q, w0_q, w1_q, w2_q;
   logic queue_empty_q;
   logic [ADDR_W-1:0] q_next;
   logic [ADDR_W-1:0] q_slot;

   assign q_slot = INPUT_LATCHED ? w1_q : w0_q;
   assign q_next = (q_slot + 1'b1) & w2_q;
   assign CALC_BUSY = (state_q != CALC_IDLE);

   always_ff @(posedge MCLK) begin
      if (RST) begin
         state_q <= CALC_IDLE;
         rd_idx_q <= '0;
         rd_last_q <= '0;
         base_q <= ADDR_RESET;
         w0_q <= ADDR_RESET;
         w1_q <= ADDR_RESET;
         w2_q <= ADDR_RESET;
         MEM_REQ <= 1'b0;
         MEM_WE <= 1'b0;
         MEM_ADDR <= ADDR_RESET;
         MEM_WDATA <= ADDR_RESET;
         MEM_ADDR_REG <= ADDR_RESET;
         END_OF_RANGE <= 1'b0;
         MACHINE_CHECK <= 1'b0;
         queue_empty_q <= 1'b0;
      end else begin
         MACHINE_CHECK <= 1'b0;
         if (act_valid && act == ACT_RESET_STROBE) begin
            END_OF_RANGE <= 1'b0;
         end
         unique case (state_q)
            CALC_IDLE: begin
               if (start_calc) begin
                  base_q <= abus_s2_q;
                  rd_idx_q <= '0;
                  queue_empty_q <= 1'b0;
                  END_OF_RANGE <= 1'b0;
                  // only the seven codes are accepted
                  if (!mode_legal(MODE_LATCHED)) begin
                     MACHINE_CHECK <= 1'b1;
                  end else if (calc_mode == MODE_SINGLE) begin
                     // end when incremented range is zero
                     MEM_ADDR_REG <= chan_addr_q[sel];
                     END_OF_RANGE <= (range_inc == '0);
                  end else if (calc_mode == MODE_TABLE) begin
                     MEM_ADDR_REG <= abus_s2_q;
                  end else begin
                     rd_last_q <= (calc_mode == MODE_CHAIN) ?
                        CHAIN_READS : QUEUE_READS;
                     MEM_REQ <= 1'b1;
                     MEM_WE <= 1'b0;
                     MEM_ADDR <= abus_s2_q;
                     state_q <= CALC_READ;
                  end
               end
            end
            CALC_READ: begin
               if (MEM_ACK) begin
                  unique case (rd_idx_q)
                     2'h0: w0_q <= MEM_RDATA;
                     2'h1: w1_q <= MEM_RDATA;
                     default: w2_q <= MEM_RDATA;
                  endcase
                  if (rd_idx_q == rd_last_q) begin
                     MEM_REQ <= 1'b0;
                     state_q <= CALC_WRITE;
                  end else begin
                     rd_idx_q <= rd_idx_q + 2'h1;
                     MEM_ADDR <= MEM_ADDR + 1'b1;
                  end
               end
            end
            CALC_WRITE: begin
               if (!MEM_REQ) begin
                  MEM_REQ <= 1'b1;
                  MEM_WE <= 1'b1;
                  if (calc_mode == MODE_CHAIN) begin
                     // write back, compare with next word
                     MEM_ADDR <= base_q;
                     MEM_WDATA <= w0_q + 1'b1;
                     MEM_ADDR_REG <= w0_q;
                     END_OF_RANGE <= (w0_q == w1_q);
                  end else if (INPUT_LATCHED) begin
                     // add at bottom, full when next meets top
                     MEM_ADDR <= base_q + QCB_BOTTOM_OFS;
                     MEM_WDATA <= q_next;
                     MEM_ADDR_REG <= base_q + QCB_BUF_OFS + w1_q;
                     END_OF_RANGE <= (q_next == w0_q);
                  end else if (w0_q == w1_q) begin
                     // empty queue ends range, no pointer update
                     MEM_REQ <= 1'b0;
                     MEM_WE <= 1'b0;
                     END_OF_RANGE <= 1'b1;
                     queue_empty_q <= 1'b1;
                     state_q <= CALC_DONE;
                  end else begin
                     MEM_ADDR <= base_q + QCB_TOP_OFS;
                     MEM_WDATA <= q_next;
                     MEM_ADDR_REG <= base_q + QCB_BUF_OFS + w0_q;
                  end
               end else if (MEM_ACK) begin
                  MEM_REQ <= 1'b0;
                  MEM_WE <= 1'b0;
                  state_q <= CALC_DONE;
               end
            end
            CALC_DONE: begin
               state_q <= CALC_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Data phase
   // ----------------------------------------------------------------
   logic read_pending_q;

   always_ff @(posedge MCLK) begin
      if (RST) begin
         PERIPH_DATA_OE <= 1'b0;
         PERIPH_DATA_OUT <= DATA_RESET;
         WB_WRITE <= 1'b0;
         WB_WDATA <= DATA_RESET;
         MEM_READ <= 1'b0;
         read_pending_q <= 1'b0;
      end else begin
         WB_WRITE <= 1'b0;
         MEM_READ <= 1'b0;
         if (act_valid && act == ACT_DATA_OFF) begin
            PERIPH_DATA_OE <= 1'b0;
         end
         // capture from the pins, write buffer takes it
         if (act_valid && act == ACT_EN_DATA_IN) begin
            PERIPH_DATA_OE <= 1'b0;
         end
         if (act_valid && act == ACT_TRIGGER && INPUT_LATCHED) begin
            WB_WDATA <= dbus_s2_q;
            WB_WRITE <= 1'b1;
         end
         // memory read, then drive the returning word
         if (act_valid && act == ACT_EN_DATA_OUT) begin
            PERIPH_DATA_OE <= 1'b1;
            if (queue_empty_q) begin
               PERIPH_DATA_OUT <= DATA_RESET;
            end else begin
               MEM_READ <= 1'b1;
               read_pending_q <= 1'b1;
            end
         end else if (read_pending_q && RETURN_VALID) begin
            PERIPH_DATA_OUT <= RETURN_DATA;
            read_pending_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_enable_set: assert property (@(posedge MCLK) disable iff (RST)
      act_valid && act == ACT_SET_EN |=> XFER_ENABLE_BROADCAST)
      else $error("enable not broadcast after set action");
   a_grant_onehot: assert property (@(posedge MCLK) disable iff (RST)
      $onehot0(XFER_GRANT))
      else $error("more than one grant active");
   a_grant_stable: assert property (@(posedge MCLK) disable iff (RST)
      XFER_GRANT != '0 && !(act_valid && act == ACT_SET_CLR_PRI)
      |=> $stable(XFER_GRANT))
      else $error("grant changed before clear");
   a_mode_latch: assert property (@(posedge MCLK) disable iff (RST)
      act_valid && act == ACT_LATCH_MODE |=>
      {MODE_LATCHED, INPUT_LATCHED} == $past(mode_s2_q))
      else $error("mode not latched");
   a_clear_drops: assert property (@(posedge MCLK) disable iff (RST)
      act_valid && act == ACT_SET_CLR_PRI |=>
      CLEAR_PRIORITY_NET && XFER_GRANT == '0)
      else $error("clear net or grants wrong");
   a_reset_both: assert property (@(posedge MCLK) disable iff (RST)
      act_valid && act == ACT_RESET_EN |=>
      !XFER_ENABLE_BROADCAST && !CLEAR_PRIORITY_NET)
      else $error("reset action left enable or clear net");
   a_illegal_mc: assert property (@(posedge MCLK) disable iff (RST)
      start_calc && !CALC_BUSY && !mode_legal(MODE_LATCHED)
      |=> MACHINE_CHECK && !CALC_BUSY)
      else $error("illegal mode without machine check");
   a_strobe_tick: assert property (@(posedge MCLK) disable iff (RST)
      $rose(DATA_STROBE) |-> $past(internal_strobe_q) &&
      $past(MEM_TIMER_TICK))
      else $error("strobe rose off a timer tick");
   a_table_eor: assert property (@(posedge MCLK) disable iff (RST)
      start_calc && !CALC_BUSY && calc_mode == MODE_TABLE &&
      mode_legal(MODE_LATCHED) |=> !END_OF_RANGE &&
      MEM_ADDR_REG == $past(abus_s2_q))
      else $error("table address wrong");
endmodule

/* dmx_periph_model.sv */
// Purpose: Peripheral controller model facing the transfer control.
// Assumes: One model stands for every slot on the bus.
// Notes:   A released data bus shows the inverse of its last value.
`timescale 1ns/100ps
module dmx_periph_model (
   input wire logic clk,
   input wire logic [9:0] want,
   input wire logic [4:0] code,
   input wire logic [17:0] addr,
   input wire logic [15:0] word,
   input wire logic enable,
   input wire logic clear,
   input wire logic [9:0] grant,
   input wire logic strobe,
   input wire logic [15:0] bus_out,
   output logic [9:0] req_n = 10'h3ff,
   output logic [4:0] mode = 5'h00,
   output logic [17:0] addr_bus = 18'h00000,
   output logic [15:0] bus_in = 16'h0000,
   output logic [15:0] seen = 16'h0000
);
   logic strobe_q = 1'b0;
   always @(posedge clk) begin
      strobe_q <= strobe;
      if (enable)
         req_n <= ~want;
      // Drop on clear, ask again next phase.
      else if (clear)
         req_n <= 10'h3ff;
      if (!enable && (grant != 10'h000)) begin
         mode <= code;
         addr_bus <= addr;
      end
      bus_in <= (strobe && code[4]) ? word : ~bus_in;
      if (strobe_q && !strobe && !code[4])
         seen <= bus_out;
   end
endmodule

/* peripheral_dmx_transfer_control_tb_top.sv */
// Purpose: Self-checking bench for the peripheral transfer control.
// Assumes: Memory and return path answer one cycle after a request.
// Notes:   Queues are never empty here, since memory reads back address+0x100.
`timescale 1ns/100ps
module peripheral_dmx_transfer_control_tb_top;
   import dmx_pkg::*;
   typedef struct {
      logic [9:0] want;
      logic [4:0] code;
      logic [17:0] addr;
      logic [17:0] ea;
      logic eor;
      logic mc;
   } row_s;
   localparam logic [15:0] RET_WORD = 16'hc35a;
   logic mclk = 1'b0, rst = 1'b1, stage8 = 1'b0, tick = 1'b0;
   logic [3:0] action = 4'h0, csel = 4'h0, ml;
   logic [9:0] want = 10'h000, req_n, grant;
   logic [4:0] code = 5'h00, mode;
   logic [17:0] addr = 18'h00000, mrd = 18'h00000, cwd = 18'h00000;
   logic [17:0] addr_bus, ma, mar;
   logic [15:0] word = 16'h0000, bus_in, pdo, wbd, seen;
   logic cwr = 1'b0, cwr_rng = 1'b0, ack = 1'b0, rv = 1'b0;
   logic oe, en, clr, strobe, eor, mc, busy, mreq, wbw, mrp, inl;
   logic mc_seen = 1'b0, wb_seen = 1'b0;
   int fail_count = 0, num_checks = 0, n;
   row_s rows [8] = '{
      '{10'h3ff, {1'b1, MODE_TABLE}, 18'h2abcd, 18'h2abcd, 1'b0, 1'b0},
      '{10'h005, {1'b0, MODE_SINGLE}, 18'h00003, 18'h01234, 1'b1, 1'b0},
      '{10'h001, {1'b1, MODE_SINGLE}, 18'h00005, 18'h00040, 1'b0, 1'b0},
      '{10'h030, {1'b0, MODE_CHAIN}, 18'h01000, 18'h01100, 1'b0, 1'b0},
      '{10'h200, {1'b1, MODE_QUEUE}, 18'h00010, 18'h00124, 1'b0, 1'b0},
      '{10'h040, {1'b0, MODE_QUEUE}, 18'h00010, 18'h00123, 1'b0, 1'b0},
      '{10'h080, 5'h0f, 18'h00000, 18'h00000, 1'b0, 1'b1},
      '{10'h100, 5'h11, 18'h00000, 18'h00000, 1'b0, 1'b1}};
   dmx_transfer_control i_dut (
      .MCLK(mclk), .RST(rst), .STAGE8(stage8), .MICROCODE_ACTION(action),
      .MEM_TIMER_TICK(tick), .XFER_REQUEST_N(req_n),
      .MODE_BIT0(mode[3]), .MODE_BIT1(mode[2]), .MODE_BIT2(mode[1]),
      .MODE_BIT3(mode[0]), .INPUT_DIRECTION(mode[4]),
      .PERIPH_ADDR_BUS(addr_bus), .PERIPH_DATA_IN(bus_in),
      .PERIPH_DATA_OUT(pdo), .PERIPH_DATA_OE(oe),
      .XFER_ENABLE_BROADCAST(en), .CLEAR_PRIORITY_NET(clr),
      .XFER_GRANT(grant), .DATA_STROBE(strobe), .END_OF_RANGE(eor),
      .MACHINE_CHECK(mc), .MODE_LATCHED(ml), .INPUT_LATCHED(inl),
      .CALC_BUSY(busy), .CHAN_WR(cwr), .CHAN_WR_RANGE(cwr_rng),
      .CHAN_SEL(csel), .CHAN_WDATA(cwd), .MEM_REQ(mreq), .MEM_WE(),
      .MEM_ADDR(ma), .MEM_WDATA(), .MEM_ACK(ack), .MEM_RDATA(mrd),
      .MEM_ADDR_REG(mar), .WB_WRITE(wbw), .WB_WDATA(wbd),
      .MEM_READ(mrp), .RETURN_VALID(rv), .RETURN_DATA(RET_WORD));
   dmx_periph_model i_ctl (
      .clk(mclk), .want(want), .code(code), .addr(addr), .word(word),
      .enable(en), .clear(clr), .grant(grant), .strobe(strobe),
      .bus_out(pdo), .req_n(req_n), .mode(mode), .addr_bus(addr_bus),
      .bus_in(bus_in), .seen(seen));
   initial forever #25 mclk = ~mclk;
   // Memory words read back as their address plus 0x100.
   always @(posedge mclk) begin
      ack <= mreq && !ack;
      mrd <= ma + 18'h00100;
      rv <= mrp;
      if (mc === 1'b1)
         mc_seen <= 1'b1;
      if (wbw === 1'b1)
         wb_seen <= 1'b1;
   end
   function automatic logic [9:0] hi(input logic [9:0] w);
      hi = 10'h000;
      for (int i = 0; i < 10; i++)
         if (w[i])
            hi = 10'h001 << i;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic act(input logic [3:0] a);
      stage8 = 1'b1;
      action = a;
      @(negedge mclk);
      stage8 = 1'b0;
      action = ACT_NOP;
      @(negedge mclk);
   endtask
   task automatic chan(input logic r, input logic [3:0] s, logic [17:0] d);
      {cwr, cwr_rng, csel, cwd} = {1'b1, r, s, d};
      @(negedge mclk);
      cwr = 1'b0;
   endtask
   task automatic pulse_tick();
      tick = 1'b1;
      @(negedge mclk);
      tick = 1'b0;
   endtask
   task automatic phase(input row_s r);
      {mc_seen, want, code, addr} = {1'b0, r.want, r.code, r.addr};
      act(ACT_SET_EN);
      check(en, 1'b1);
      for (n = 0; grant === 10'h000 && n < 20; n++)
         @(negedge mclk);
      check(grant, hi(r.want));
      act(ACT_RESET_EN);
      repeat (4) @(negedge mclk);
      act(ACT_LATCH_MODE);
      check({inl, ml, grant}, {r.code, hi(r.want)});
      act(ACT_SET_CLR_PRI);
      check({clr, grant}, 11'h400);
      act(ACT_RESET_EN);
      check({en, clr}, 2'b00);
      act(ACT_CALC_ADDR);
      for (n = 0; busy !== 1'b0 && n < 50; n++)
         @(negedge mclk);
      @(negedge mclk);
      check(mc_seen, r.mc);
      if (!r.mc)
         check({eor, mar}, {r.eor, r.ea});
   endtask
   initial begin
      #500000;
      fail_count++;
      give_verdict();
   end
   initial begin
      repeat (16) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      check({en, clr, grant, strobe, eor, oe, mc}, 0);
      chan(1'b0, 4'h3, 18'h01234);
      chan(1'b1, 4'h3, 18'h3ffff);
      chan(1'b0, 4'h5, 18'h00040);
      chan(1'b1, 4'h5, 18'h3fff0);
      foreach (rows[i])
         phase(rows[i]);
      {want, word} = {10'h000, 16'h5aa5};
      act(ACT_SET_STROBE);
      repeat (3) @(negedge mclk);
      check(strobe, 1'b0);
      pulse_tick();
      repeat (2) @(negedge mclk);
      check(strobe, 1'b1);
      act(ACT_SET_EN);
      check({en, strobe}, 2'b11);
      act(ACT_RESET_EN);
      act(ACT_EN_DATA_IN);
      act(ACT_TRIGGER);
      check({wb_seen, wbd}, {1'b1, 16'h5aa5});
      act(ACT_RESET_STROBE);
      check(strobe, 1'b0);
      phase('{10'h002, {1'b0, MODE_TABLE}, 18'h00777, 18'h00777, 0, 0});
      act(ACT_SET_STROBE);
      pulse_tick();
      act(ACT_EN_DATA_OUT);
      repeat (3) @(negedge mclk);
      check({oe, pdo}, {1'b1, RET_WORD});
      act(ACT_RESET_STROBE);
      check(seen, RET_WORD);
      act(ACT_DATA_OFF);
      check(oe, 1'b0);
      rst = 1'b1;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      check({en, clr, grant, strobe, eor, oe}, 0);
      give_verdict();
   end
endmodule
